// *** hw/unit_enable_consts.vh ***
// Register map, field positions, reset values and timing counts for the unit enable block
`ifndef UNIT_ENABLE_CONSTS_VH
`define UNIT_ENABLE_CONSTS_VH

`define ADDR_W                 12
`define OFF_PERIPHERAL_SETTINGS 12'h000
`define OFF_WHOLE_UNIT_ENABLE   12'h004
`define OFF_WHOLE_UNIT_STATE    12'h008
`define OFF_OWN_NODE_ID         12'h00c
`define OFF_SUB_ENABLE_BASE     12'h040
`define OFF_SUB_STATE_BASE      12'h080
`define NUM_BLOCKS             9

`define PRESCALE_LSB           4
`define PRESCALE_MSB           7
`define PLL_MSB                3
`define SHORT_ID_LSB           16
`define SHORT_ID_MSB           23
`define LONG_ID_MSB            15

`define RST_SETTINGS           32'h0000_0000
`define RST_SHORT_ID           8'hff
`define RST_LONG_ID            16'hffff

// Cycles a domain's gate/reset takes before status follows
`define SETTLE_CYCLES          4'h4
`endif

// *** hw/unit_enable_and_clock_setup.v ***
// Enable, clock gating, prescaler and node identifier control over APB
// What this block does
// - Prescaler codes 7 to 11 pick the mid timer clock ranges, one per step.
// - Prescaler codes 12 to 15 pick the top timer clock ranges.
// - Prescaler field reloads a divider of the APB clock, factor 1 to 16.
// - Settings bit 3 drives lane macro 4 PLL enable; 0 turns it off.
// - Settings bit 2 drives lane macro 3 PLL enable.
// - Settings bit 1 drives lane macro 2 PLL enable.
// - Settings bit 0 drives lane macro 1 PLL enable.
// - Whole unit enable bit 0 resets and gates every domain when 0.
// - Whole unit status bit 0 shows the actual global reset state.
// - Nine block enable registers each reset and gate one block.
// - Nine block status registers show each block's actual state.
// - Node identifier register holds 8-bit and 16-bit source identifiers.
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/10ps
`include "unit_enable_consts.vh"

module unit_enable_and_clock_setup (
  // APB clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Timer clock enable and lane PLLs
  output reg         timer_tick,
  output reg  [3:0]  lane_pll_on,
  // Domain resets (active low) and clock enables
  output reg         unit_rst_n,
  output reg         unit_clk_on,
  output reg  [8:0]  block_rst_n,
  output reg  [8:0]  block_clk_on,
  // Source identifiers for outgoing packets
  output reg  [7:0]  short_node_id,
  output reg  [15:0] long_node_id
);

  localparam NB = `NUM_BLOCKS;

  reg  [31:0] settings_r;
  reg         unit_en_r;
  reg  [8:0]  block_en_r;
  reg  [7:0]  short_id_r;
  reg  [15:0] long_id_r;
  reg  [3:0]  div_cnt_r;
  reg  [3:0]  unit_cnt_r;
  reg         unit_stat_r;
  reg  [3:0]  blk_cnt_r [0:NB-1];
  reg  [8:0]  blk_stat_r;
  reg  [31:0] rdata_nxt;
  reg         err_nxt;
  reg  [3:0]  idx;

  wire        access = psel & penable & ~pready;
  wire        wr_acc = access & pwrite;
  wire [3:0]  prescale = settings_r[`PRESCALE_MSB:`PRESCALE_LSB];
  wire [11:0] sub_en_base = `OFF_SUB_ENABLE_BASE;
  wire [11:0] sub_st_base = `OFF_SUB_STATE_BASE;
  wire        in_sub_en = (paddr[11:6] == sub_en_base[11:6]) && (paddr[5:2] < 4'd9);
  wire        in_sub_st = (paddr[11:6] == sub_st_base[11:6]) && (paddr[5:2] < 4'd9);

  // Read decode; unmapped addresses answer with pslverr
  always @* begin
    rdata_nxt = 32'h0000_0000;
    err_nxt   = 1'b0;
    idx       = paddr[5:2];
    if (paddr[1:0] != 2'b00) begin
      err_nxt = 1'b1;
    end else if (paddr == `OFF_PERIPHERAL_SETTINGS) begin
      rdata_nxt = settings_r;
    end else if (paddr == `OFF_WHOLE_UNIT_ENABLE) begin
      rdata_nxt = {31'h0000_0000, unit_en_r};
    end else if (paddr == `OFF_WHOLE_UNIT_STATE) begin
      rdata_nxt = {31'h0000_0000, unit_stat_r};
    end else if (paddr == `OFF_OWN_NODE_ID) begin
      rdata_nxt = {8'h00, short_id_r, long_id_r};
    end else if (in_sub_en) begin
      rdata_nxt = {31'h0000_0000, block_en_r[idx]};
    end else if (in_sub_st) begin
      rdata_nxt = {31'h0000_0000, blk_stat_r[idx]};
    end else begin
      err_nxt = 1'b1;
    end
  end

  // One wait state: the answer comes one edge after the access phase opens
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access;
      pslverr <= access & err_nxt;
      prdata  <= (access & ~pwrite) ? rdata_nxt : 32'h0000_0000;
    end
  end

  // Register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settings_r <= `RST_SETTINGS;
      unit_en_r  <= 1'b0;
      block_en_r <= 9'h000;
      short_id_r <= `RST_SHORT_ID;
      long_id_r  <= `RST_LONG_ID;
    end else if (wr_acc && !err_nxt) begin
      if (paddr == `OFF_PERIPHERAL_SETTINGS) begin
        // Only prescaler and PLL fields are kept; other bits read 0
        settings_r <= {24'h00_0000, pwdata[7:0]};
      end
      if (paddr == `OFF_WHOLE_UNIT_ENABLE) begin
        unit_en_r <= pwdata[0];
      end
      if (paddr == `OFF_OWN_NODE_ID) begin
        short_id_r <= pwdata[`SHORT_ID_MSB:`SHORT_ID_LSB];
        long_id_r  <= pwdata[`LONG_ID_MSB:0];
      end
      if (in_sub_en) begin
        block_en_r[idx] <= pwdata[0];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_r  <= 4'h0;
      timer_tick <= 1'b0;
    end else if (div_cnt_r == 4'h0) begin
      div_cnt_r  <= prescale;
      timer_tick <= unit_stat_r;
    end else begin
      div_cnt_r  <= div_cnt_r - 4'h1;
      timer_tick <= 1'b0;
    end
  end

  // Lane PLL enables and identifiers to the packet path
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane_pll_on   <= 4'h0;
      short_node_id <= `RST_SHORT_ID;
      long_node_id  <= `RST_LONG_ID;
    end else begin
      lane_pll_on   <= settings_r[`PLL_MSB:0];
      short_node_id <= short_id_r;
      long_node_id  <= long_id_r;
    end
  end

  // Global domain: on enable, clocks start then reset lifts; off drops clock and reset on the same edge.
  // Status is only updated once the settle count has run out.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_clk_on <= 1'b0;
      unit_rst_n  <= 1'b0;
      unit_cnt_r  <= 4'h0;
      unit_stat_r <= 1'b0;
    end else begin
      unit_clk_on <= unit_en_r;
      unit_rst_n  <= unit_en_r & unit_clk_on;
      // status waits for settle
      // Count only once both gate and reset match the request and status lags
      if (unit_rst_n != unit_en_r || unit_clk_on != unit_en_r ||
          unit_stat_r == unit_en_r) begin
        unit_cnt_r <= 4'h0;
      end else if (unit_cnt_r == `SETTLE_CYCLES) begin
        unit_cnt_r <= 4'h0;
        unit_stat_r <= unit_en_r;
      end else begin
        unit_cnt_r <= unit_cnt_r + 4'h1;
      end
    end
  end

  // Per-block domains, also held while the whole unit is off
  genvar g;
  generate
    for (g = 0; g < NB; g = g + 1) begin : blk
      wire want = block_en_r[g] & unit_en_r;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          block_clk_on[g] <= 1'b0;
          block_rst_n[g]  <= 1'b0;
          blk_cnt_r[g]    <= 4'h0;
          blk_stat_r[g]   <= 1'b0;
        end else begin
          block_clk_on[g] <= want;
          block_rst_n[g]  <= want & block_clk_on[g];
          if (block_rst_n[g] != want || block_clk_on[g] != want ||
              blk_stat_r[g] == want) begin
            blk_cnt_r[g] <= 4'h0;
          end else if (blk_cnt_r[g] == `SETTLE_CYCLES) begin
            blk_cnt_r[g] <= 4'h0;
            blk_stat_r[g] <= want;
          end else begin
            blk_cnt_r[g] <= blk_cnt_r[g] + 4'h1;
          end
        end
      end
    end
  endgenerate

endmodule

// *** tb/unit_enable_props.sv ***
// Port-level assertions for the unit enable block
`timescale 1ns/10ps
module unit_enable_props (
  // APB side
  input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  // Unit controls
  input wire logic        timer_tick, unit_rst_n, unit_clk_on,
  input wire logic [3:0]  lane_pll_on,
  input wire logic [8:0]  block_rst_n, block_clk_on,
  input wire logic [7:0]  short_node_id,
  input wire logic [15:0] long_node_id
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr = psel && penable && pwrite && pready;
  AST_ACK: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait state");
  AST_PULSE: assert property (pready |=> !pready) else $error("pready held");
  AST_ERR: assert property (pslverr |-> pready) else $error("pslverr outside answer");
  AST_RDZ: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
  AST_PLL: assert property (
    wr && paddr == 12'h000 |=> lane_pll_on == $past(pwdata[3:0])) else $error("pll enables");
  AST_ID: assert property (
    wr && paddr == 12'h00c |=> {short_node_id, long_node_id} == $past(pwdata[23:0]))
    else $error("node id outputs");
  AST_DIS: assert property (
    wr && paddr == 12'h004 && !pwdata[0] |-> ##[0:2] !unit_clk_on && !unit_rst_n)
    else $error("unit not stopped");
  AST_ORD: assert property (
    $rose(unit_rst_n) |-> unit_clk_on) else $error("reset left before clock on");
  AST_GATE: assert property (
    !unit_clk_on [*3] |-> block_clk_on == 9'h0) else $error("block clocked while unit off");
  AST_TICK: assert property (
    !unit_clk_on [*8] |-> !timer_tick) else $error("tick while unit off");
  cover property (wr && paddr == 12'h004 && pwdata[0]);
  cover property (pslverr);
  cover property ($rose(unit_rst_n));
endmodule

// *** tb/unit_enable_and_clock_setup_tb_top.sv ***
// Self-checking bench for the unit enable block
`timescale 1ns/10ps
`define CHK(n,e,g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module unit_enable_and_clock_setup_tb_top;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        pready, pslverr, timer_tick, unit_rst_n, unit_clk_on, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, v;
  logic [3:0]  lane_pll_on;
  logic [8:0]  block_rst_n, block_clk_on;
  logic [7:0]  short_node_id;
  logic [15:0] long_node_id;
  int          err_total, total_checks, gp;
  always #25 pclk = ~pclk;
  unit_enable_and_clock_setup unit_enable_and_clock_setup_i (.*);
  task summarize;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (int c = 0; pready !== 1'b1; c++) begin
      if (c == 20) begin err_total++; summarize(); end
      @(posedge pclk);
    end
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic poll(input logic [11:0] a, input logic e, input string n);
    for (int k = 0; k < 20; k++) begin apb(0, a, 0); if (rd[0] === e) break; end
    `CHK(n, e, rd[0])
  endtask
  // Cycles between two timer ticks, bounded so a dead divider cannot hang
  task automatic gap(output int g);
    int n = 0;
    while (timer_tick !== 1'b1 && n < 40) begin @(posedge pclk); n++; end
    @(posedge pclk); g = 1;
    while (timer_tick !== 1'b1 && g < 40) begin @(posedge pclk); g++; end
  endtask
  function automatic logic [31:0] exp_rd(input logic [11:0] a, input logic [31:0] d);
    if (a == 12'h000) return d & 32'hff;
    if (a == 12'h00c) return d & 32'hff_ffff;
    return d & 32'h1;
  endfunction
  initial begin
    void'($urandom(87));
    repeat (8) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h000, 0); `CHK("settings", 32'h0, rd)
    apb(0, 12'h008, 0); `CHK("unit state", 32'h0, rd)
    apb(0, 12'h00c, 0); `CHK("node id", 32'h00ff_ffff, rd)
    apb(1, 12'h004, 1); poll(12'h008, 1, "unit state");
    `CHK("unit rst", 1'b1, unit_rst_n)
    for (int p = 7; p < 16; p++) begin
      v = ($urandom & 32'hffff_ff0f) | (p << 4);
      apb(1, 12'h000, v); apb(0, 12'h000, 0);
      `CHK("settings", exp_rd(12'h000, v), rd)
      `CHK("pll", v[3:0], lane_pll_on)
      gap(gp); `CHK("tick gap", p + 1, gp)
    end
    for (int b = 0; b < 9; b++) begin
      v = $urandom;
      apb(1, 12'(12'h040 + 4 * b), v); apb(0, 12'(12'h040 + 4 * b), 0);
      `CHK("block en", exp_rd(12'h040, v), rd)
      poll(12'(12'h080 + 4 * b), v[0], "block state");
      `CHK("block rst", v[0], block_rst_n[b])
    end
    v = $urandom; apb(1, 12'h00c, v); apb(0, 12'h00c, 0);
    `CHK("node id", exp_rd(12'h00c, v), rd)
    `CHK("id out", v[23:0], {short_node_id, long_node_id})
    apb(1, 12'h010, '1); `CHK("slverr", 1'b1, er)
    // Status is read-only: a write must not move it
    apb(1, 12'h008, 0); apb(0, 12'h008, 0); `CHK("unit state", 32'h1, rd)
    apb(1, 12'h004, 0); poll(12'h008, 0, "unit state");
    repeat (12) @(posedge pclk);
    `CHK("blocks off", 9'h0, block_clk_on)
    summarize();
  end
endmodule
bind unit_enable_and_clock_setup unit_enable_props unit_enable_props_i (.*);
